// ---- design/dsf_flag_bank.sv ----
`timescale 1ns/1ps

// Bank of sticky flags: set wins over clear, reset forces zero
module dsf_flag_bank #(
   parameter int unsigned WIDTH = 6
) (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic [WIDTH-1:0] set_i,
   input  wire logic [WIDTH-1:0] clr_i,
   output logic      [WIDTH-1:0] flag_o
);

   logic [WIDTH-1:0] flag_r;    // Held flag state
   logic [WIDTH-1:0] flag_nxt;  // Next flag state

   // Set has priority so an event in the clearing cycle survives
   always_comb begin
      flag_nxt = set_i | (flag_r & ~clr_i);
   end

   // Flags drop to zero under reset
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flag_r <= '0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag_o = flag_r;

endmodule : dsf_flag_bank

// ---- design/dsf_pkg.sv ----
package dsf_pkg;

   // Bus geometry
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned ADDR_W       = 12;
   localparam int unsigned REG_W        = 16;

   // Register indices; the byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_SYS_CTRL   = 12'h000;
   localparam logic [ADDR_W-1:0] IDX_STATUS     = 12'h002;
   localparam logic [ADDR_W-1:0] IDX_FLAG_CLEAR = 12'h004;
   localparam logic [1:0]        BYTE_SHIFT     = 2'h2;

   // Status and clear bit positions, shared by both registers except the buffer select
   localparam int unsigned BIT_DMA_DONE     = 13;
   localparam int unsigned BIT_CMD_ERROR    = 12;
   localparam int unsigned BIT_VBLANK       = 11;
   localparam int unsigned BIT_CMD_END      = 10;
   localparam int unsigned BIT_CMD_SUSPEND  = 9;
   localparam int unsigned BIT_DISP_BUF_SEL = 8;
   localparam int unsigned BIT_DRAW_BREAK   = 7;

   // System control fields
   localparam int unsigned BIT_DRAW_SOFT_RESET = 15;
   localparam int unsigned BIT_DISPLAY_RESET   = 14;
   localparam int unsigned BIT_DMA_MODE_HI     = 5;
   localparam int unsigned BIT_DMA_MODE_LO     = 4;

   // Index of each sticky flag inside the flag bank
   localparam int unsigned NUM_FLAGS   = 6;
   localparam int unsigned FI_DMA      = 0;
   localparam int unsigned FI_CMD_ERR  = 1;
   localparam int unsigned FI_VBLANK   = 2;
   localparam int unsigned FI_CMD_END  = 3;
   localparam int unsigned FI_SUSPEND  = 4;
   localparam int unsigned FI_BREAK    = 5;

   // Command code layout: opcode sits above the attribute field
   localparam int unsigned CMD_W       = 16;
   localparam int unsigned OPCODE_LSB  = 11;
   localparam int unsigned OPCODE_W    = 5;

   // Reset values
   localparam logic [REG_W-1:0]  SYS_CTRL_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] RDATA_RESET    = 32'h0000_0000;

endpackage : dsf_pkg

// ---- design/dsf_status_flags.sv ----
`timescale 1ns/1ps

// How it works
// - DMA flag sets when armed count hits zero
// - DMA flag sticky until reset, clear or DMA start
// - Command error halts fetch and execution
// - Error cleared by reset, soft reset, clear
// - Blank flag sets at next blanking start
// - Display reset or clear zeroes blank flag
// - End flag set when no command runs
// - End flag sticky until reset/soft reset/clear
// - Suspend flag on frame change before end
// - Suspend sticky until reset/soft reset/clear
// - Buffer flag shows which start address used
// - Break flag sets on break stop
// - Break sticky until reset/soft reset/clear
// - Reset keeps display buffer flag
// - Reset zeroes all other flags
// - Clear register bits clear flags, read zero
module dsf_status_flags
   import dsf_pkg::*;
#(
   parameter logic [31:0] LEGAL_OPCODE_MAP = 32'h0000_ffff  // One bit per defined opcode
) (
   input  wire logic              sys_clk_i,
   input  wire logic              reset_n_i,
   // APB slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [DATA_W-1:0] pwdata_i,
   output logic      [DATA_W-1:0] prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Engine events, same clock domain
   input  wire logic              dma_count_zero_i,
   input  wire logic              cmd_fetch_i,
   input  wire logic [CMD_W-1:0]  cmd_code_i,
   input  wire logic              cmd_active_i,
   input  wire logic              cmd_done_i,
   input  wire logic              vblank_i,
   input  wire logic              display_change_mode_i,
   input  wire logic              frame_change_suspend_i,
   input  wire logic              render_end_irq_i,
   input  wire logic              display_buf_b_i,
   input  wire logic              draw_break_stop_i,
   // Control back to the engines
   output logic                   drawing_halt_o,
   output logic                   cmd_accept_o,
   output logic [1:0]             dma_mode_o,
   output logic                   drawing_soft_reset_o,
   output logic                   display_reset_o
);

   // Register index decode of a byte address
   function automatic logic [ADDR_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
      reg_index = addr >> BYTE_SHIFT;
   endfunction : reg_index

   // Only the opcode decides legality
   function automatic logic opcode_illegal(input logic [CMD_W-1:0] code);
      logic [OPCODE_W-1:0] op;
      op = code[OPCODE_LSB +: OPCODE_W];
      opcode_illegal = ~LEGAL_OPCODE_MAP[op];
   endfunction : opcode_illegal

   logic [REG_W-1:0]     sys_ctrl_r;      // System control register
   logic [DATA_W-1:0]    prdata_r;        // Read data captured at setup
   logic                 pready_r;        // High during access phase
   logic                 pslverr_r;       // Unmapped address answer
   logic                 dma_armed_r;     // DMA started, waiting for zero
   logic                 vblank_d_r;      // Blanking level one cycle ago
   logic                 render_seen_r;   // Render end since suspend clear
   logic                 disp_buf_b_r;    // Active start address select
   logic                 soft_reset_d_r;  // Registered soft reset level
   logic                 disp_reset_d_r;  // Registered display reset level
   logic                 cmd_accept_r;    // Fetch acceptance to engine

   logic                 setup_phase;     // APB setup cycle
   logic                 access_done;     // APB access completing now
   logic                 wr_done;         // Completing write
   logic [ADDR_W-1:0]    acc_index;       // Index of current access
   logic                 addr_mapped;     // Address hits a register
   logic                 sys_wr;          // Write to system control
   logic                 clr_wr;          // Write to flag clear register
   logic                 dma_start;       // DMA transfer mode started
   logic [NUM_FLAGS-1:0] flag_set;        // Set events per flag
   logic [NUM_FLAGS-1:0] flag_clr;        // Clear requests per flag
   logic [NUM_FLAGS-1:0] flags;           // Sticky flag state
   logic [REG_W-1:0]     status_word;     // Assembled status image

   // Bus phase decode
   always_comb begin
      setup_phase = psel_i & ~penable_i;
      access_done = psel_i & penable_i & pready_r;
      wr_done     = access_done & pwrite_i;
      acc_index   = reg_index(paddr_i);
      addr_mapped = (acc_index == IDX_SYS_CTRL) | (acc_index == IDX_STATUS) |
                    (acc_index == IDX_FLAG_CLEAR);
      sys_wr      = wr_done & (acc_index == IDX_SYS_CTRL);
      clr_wr      = wr_done & (acc_index == IDX_FLAG_CLEAR);
   end

   // Starting a DMA mode means writing 01 or 11 to the mode field
   always_comb begin
      dma_start = sys_wr & pwdata_i[BIT_DMA_MODE_LO];
   end

   // Status image; bits other than 7 to 13 read zero
   always_comb begin
      status_word                   = '0;
      status_word[BIT_DMA_DONE]     = flags[FI_DMA];
      status_word[BIT_CMD_ERROR]    = flags[FI_CMD_ERR];
      status_word[BIT_VBLANK]       = flags[FI_VBLANK];
      status_word[BIT_CMD_END]      = flags[FI_CMD_END];
      status_word[BIT_CMD_SUSPEND]  = flags[FI_SUSPEND];
      status_word[BIT_DISP_BUF_SEL] = disp_buf_b_r;
      status_word[BIT_DRAW_BREAK]   = flags[FI_BREAK];
   end

   // Zero-wait slave: ready rises in every access phase
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= setup_phase;
         pslverr_r <= setup_phase & ~addr_mapped;
      end
   end

   // Read data captured in setup, held through the access
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prdata_r <= RDATA_RESET;
      end else if (setup_phase && !pwrite_i) begin
         case (acc_index)
            IDX_SYS_CTRL: begin
               prdata_r <= {{(DATA_W-REG_W){1'b0}}, sys_ctrl_r};
            end
            IDX_STATUS: begin
               prdata_r <= {{(DATA_W-REG_W){1'b0}}, status_word};
            end
            IDX_FLAG_CLEAR: begin
               prdata_r <= RDATA_RESET;
            end
            default: begin
               prdata_r <= RDATA_RESET;
            end
         endcase
      end else if (setup_phase) begin
         prdata_r <= RDATA_RESET;
      end
   end

   // System control: only documented fields are kept
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sys_ctrl_r <= SYS_CTRL_RESET;
      end else if (sys_wr) begin
         sys_ctrl_r                      <= SYS_CTRL_RESET;
         sys_ctrl_r[BIT_DRAW_SOFT_RESET] <= pwdata_i[BIT_DRAW_SOFT_RESET];
         sys_ctrl_r[BIT_DISPLAY_RESET]   <= pwdata_i[BIT_DISPLAY_RESET];
         sys_ctrl_r[BIT_DMA_MODE_HI]     <= pwdata_i[BIT_DMA_MODE_HI];
         sys_ctrl_r[BIT_DMA_MODE_LO]     <= pwdata_i[BIT_DMA_MODE_LO];
      end
   end

   // Reset levels registered once more so outputs match the flags
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         soft_reset_d_r <= 1'b0;
         disp_reset_d_r <= 1'b0;
      end else begin
         soft_reset_d_r <= sys_ctrl_r[BIT_DRAW_SOFT_RESET];
         disp_reset_d_r <= sys_ctrl_r[BIT_DISPLAY_RESET];
      end
   end

   // DMA arming; a stale zero count before start is ignored
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dma_armed_r <= 1'b0;
      end else if (dma_start) begin
         dma_armed_r <= 1'b1;
      end else if (sys_wr || dma_count_zero_i) begin
         // Completion or a return to normal mode disarms
         dma_armed_r <= 1'b0;
      end
   end

   // Blanking edge history for the once-per-field set
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         vblank_d_r <= 1'b0;
      end else begin
         vblank_d_r <= vblank_i;
      end
   end

   // Render end seen since suspend flag was last cleared
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         render_seen_r <= 1'b0;
      end else if (render_end_irq_i) begin
         render_seen_r <= 1'b1;
      end else if (flag_clr[FI_SUSPEND]) begin
         render_seen_r <= 1'b0;
      end
   end

   // No reset: buffer select survives a device reset
   // buffer flag kept
   always_ff @(posedge sys_clk_i) begin
      disp_buf_b_r <= display_buf_b_i;
   end

   // Fetch grant to the drawing engine
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmd_accept_r <= 1'b0;
      end else begin
         cmd_accept_r <= ~flag_set[FI_CMD_ERR] & ~(flags[FI_CMD_ERR] & ~flag_clr[FI_CMD_ERR]);
      end
   end

   // Set events for each flag
   always_comb begin
      flag_set = '0;
      flag_set[FI_DMA]     = dma_armed_r & dma_count_zero_i;
      flag_set[FI_CMD_ERR] = cmd_fetch_i & cmd_accept_r & opcode_illegal(cmd_code_i);
      flag_set[FI_VBLANK]  = vblank_i & ~vblank_d_r;
      flag_set[FI_CMD_END] = cmd_done_i | ~cmd_active_i;
      flag_set[FI_SUSPEND] = display_change_mode_i & frame_change_suspend_i & ~render_seen_r;
      flag_set[FI_BREAK]   = draw_break_stop_i;
   end

   // Clear requests: clear register bits, soft and display reset, DMA start
   always_comb begin
      flag_clr = '0;
      flag_clr[FI_DMA]     = (clr_wr & pwdata_i[BIT_DMA_DONE]) | dma_start;
      flag_clr[FI_CMD_ERR] = (clr_wr & pwdata_i[BIT_CMD_ERROR]) |
                             sys_ctrl_r[BIT_DRAW_SOFT_RESET];
      flag_clr[FI_VBLANK]  = (clr_wr & pwdata_i[BIT_VBLANK]) |
                             sys_ctrl_r[BIT_DISPLAY_RESET];
      flag_clr[FI_CMD_END] = (clr_wr & pwdata_i[BIT_CMD_END]) |
                             sys_ctrl_r[BIT_DRAW_SOFT_RESET];
      flag_clr[FI_SUSPEND] = (clr_wr & pwdata_i[BIT_CMD_SUSPEND]) |
                             sys_ctrl_r[BIT_DRAW_SOFT_RESET];
      flag_clr[FI_BREAK]   = (clr_wr & pwdata_i[BIT_DRAW_BREAK]) |
                             sys_ctrl_r[BIT_DRAW_SOFT_RESET];
   end

   // Sticky storage; reset zeroes all but the buffer flag
   // reset zeroes flags
   dsf_flag_bank #(
      .WIDTH     (NUM_FLAGS)
   ) u_flag_bank (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (flag_set),
      .clr_i     (flag_clr),
      .flag_o    (flags)
   );

   // Outputs, all from flip-flops
   assign prdata_o             = prdata_r;
   assign pready_o             = pready_r;
   assign pslverr_o            = pslverr_r;
   assign drawing_halt_o       = flags[FI_CMD_ERR];
   assign cmd_accept_o         = cmd_accept_r;
   assign dma_mode_o           = {sys_ctrl_r[BIT_DMA_MODE_HI], sys_ctrl_r[BIT_DMA_MODE_LO]};
   assign drawing_soft_reset_o = soft_reset_d_r;
   assign display_reset_o      = disp_reset_d_r;

endmodule : dsf_status_flags

// ---- test/drawing_status_flags_test.sv ----
`timescale 1ns/1ps
module drawing_status_flags_test;
   import dsf_pkg::*;
   localparam logic [31:0] LEGAL = 32'h0000_ffff;  // Opcodes 0..15 defined
   localparam logic [ADDR_W-1:0] A_SYS = IDX_SYS_CTRL << BYTE_SHIFT;
   localparam logic [ADDR_W-1:0] A_ST  = IDX_STATUS << BYTE_SHIFT;
   localparam logic [ADDR_W-1:0] A_CLR = IDX_FLAG_CLEAR << BYTE_SHIFT;
   logic clk, reset_n, psel, pen, pwr, rdy, err, accept, halt, srst, drst;
   logic dz, fetch, act, done_p, vb, mode, susp, rend, bufb, drawing_break_flag;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rdat;
   logic [CMD_W-1:0]  code;
   logic [1:0]        dmode;
   logic [4:0]        op;
   logic              rerr;
   int fails, checks, cyc, t;
   int ev[5] = '{7, 9, 10, 11, 12};  // Event-driven status bits

   dsf_status_flags #(.LEGAL_OPCODE_MAP(LEGAL)) DUT (
      .sys_clk_i(clk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(rdy), .pslverr_o(err), .dma_count_zero_i(dz), .cmd_fetch_i(fetch),
      .cmd_code_i(code), .cmd_active_i(act), .cmd_done_i(done_p), .vblank_i(vb),
      .display_change_mode_i(mode), .frame_change_suspend_i(susp),
      .render_end_irq_i(rend), .display_buf_b_i(bufb), .draw_break_stop_i(drawing_break_flag),
      .drawing_halt_o(halt), .cmd_accept_o(accept), .dma_mode_o(dmode),
      .drawing_soft_reset_o(srst), .display_reset_o(drst));
   dsf_host_model HOST (.sys_clk_i(clk), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
      .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(rdy),
      .pslverr_i(err));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Watchdog against a hung handshake
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end

   function logic bad_op(input logic [4:0] o);
      return !LEGAL[o];
   endfunction : bad_op
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h want %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      HOST.xfer(1'b1, a, d, rdat, rerr);
   endtask : wr
   task rd(input logic [ADDR_W-1:0] a);
      HOST.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
   endtask : rd
   task tend();
      t++;
      $display("test %0d done", t);
   endtask : tend
   // One-cycle event on the engine input behind a status bit
   task fire(input int b);
      @(posedge clk);
      case (b)
         0:  rend <= 1'b1;
         7:  drawing_break_flag <= 1'b1;
         9:  susp <= 1'b1;
         10: done_p <= 1'b1;
         11: vb <= 1'b1;
         default: begin
            fetch <= 1'b1;
            code <= {op, 11'($urandom)};
         end
      endcase
      @(posedge clk);
      {rend, drawing_break_flag, susp, done_p, vb, fetch} <= '0;
   endtask : fire
   task end_sim();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim

   initial begin
      {reset_n, dz, fetch, done_p, vb, susp, rend, bufb, drawing_break_flag, code} = '0;
      act = 1'b1;  // Busy engine, so the end flag moves only on done pulses
      mode = 1'b1;
      op = 5'h1f;
      void'($urandom(48004));
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      rd(A_ST);
      chk(rdat, 32'h0000_0000);
      rd(12'h00c);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0000_0000);
      tend();
      // Set, survive other clears, clear, clear register reads zero
      foreach (ev[i]) begin
         fire(ev[i]);
         rd(A_ST);
         chk(rdat[ev[i]], 1'b1);
         wr(A_CLR, $urandom & ~(32'h1 << ev[i]));
         rd(A_ST);
         chk(rdat[ev[i]], 1'b1);
         wr(A_CLR, 32'h1 << ev[i]);
         rd(A_CLR);
         chk(rdat, 32'h0000_0000);
         rd(A_ST);
         chk(rdat[ev[i]], 1'b0);
      end
      tend();
      // Random opcodes; attribute bits never judged
      repeat (8) begin
         op = 5'($urandom);
         fire(12);
         rd(A_ST);
         chk(rdat[12], bad_op(op));
         chk(accept, !bad_op(op));
         chk(halt, bad_op(op));
         wr(A_CLR, 32'h1000);
         rd(A_ST);
         chk({rdat[12], accept}, 2'b01);
         chk(halt, 1'b0);
      end
      tend();
      // Arming clears, count zero sets, disarmed stays clear
      wr(A_SYS, 32'h10);
      rd(A_ST);
      chk({rdat[13], dmode}, 3'b001);
      @(posedge clk);
      dz <= 1'b1;
      rd(A_ST);
      chk(rdat[13], 1'b1);
      dz <= 1'b0;
      // Other clear bits leave the completion flag standing
      wr(A_CLR, $urandom & ~32'h2000);
      rd(A_ST);
      chk(rdat[13], 1'b1);
      wr(A_SYS, 32'h30);
      rd(A_ST);
      chk(rdat[13], 1'b0);
      wr(A_SYS, 32'h0);
      dz <= 1'b1;
      rd(A_ST);
      chk(rdat[13], 1'b0);
      dz <= 1'b0;
      tend();
      // Soft reset and display reset bits
      op = 5'h1f;
      foreach (ev[i]) fire(ev[i]);
      wr(A_SYS, 32'h8000);
      rd(A_ST);
      chk({rdat[30:0] & 31'h1680, srst}, 32'h1);
      wr(A_SYS, 32'h4000);
      rd(A_ST);
      chk({rdat[11], drst}, 2'b01);
      wr(A_SYS, 32'h0);
      tend();
      // Render end since clear blocks the suspend flag
      wr(A_CLR, 32'h200);
      fire(0);
      fire(9);
      rd(A_ST);
      chk(rdat[9], 1'b0);
      // Set and clear meet at one edge
      fork
         wr(A_CLR, 32'h80);
         begin
            repeat (2) @(posedge clk);
            drawing_break_flag <= 1'b1;
            @(posedge clk);
            drawing_break_flag <= 1'b0;
         end
      join
      rd(A_ST);
      chk(rdat[7], 1'b1);
      tend();
      // Buffer flag follows the start address select
      repeat (4) begin
         @(posedge clk);
         bufb <= 1'($urandom);
         repeat (2) @(posedge clk);
         rd(A_ST);
         chk(rdat[8], bufb);
      end
      // Mid-run reset keeps only the buffer flag
      @(posedge clk);
      bufb <= 1'b1;
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rd(A_ST);
      chk(rdat, 32'h0000_0100);
      tend();
      end_sim();
   end
endmodule : drawing_status_flags_test

// ---- test/dsf_host_model.sv ----
`timescale 1ns/1ps
// Host side: APB master, used through its transfer task
module dsf_host_model
   import dsf_pkg::*;
(
   input  wire logic              sys_clk_i,
   output logic                   psel_o,
   output logic                   penable_o,
   output logic                   pwrite_o,
   output logic      [ADDR_W-1:0] paddr_o,
   output logic      [DATA_W-1:0] pwdata_o,
   input  wire logic [DATA_W-1:0] prdata_i,
   input  wire logic              pready_i,
   input  wire logic              pslverr_i
);
   // Bus idle from time zero
   initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;

   // One transfer, held until pready is seen high at an edge
   // software clears by writing ones
   task xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
             output logic [DATA_W-1:0] r, output logic e);
      @(posedge sys_clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge sys_clk_i);
      penable_o <= 1'b1;
      // No wait length assumed; only the bench watchdog ends this
      do @(posedge sys_clk_i); while (pready_i !== 1'b1);
      r = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
   endtask : xfer
endmodule : dsf_host_model

// ---- test/dsf_status_flags_props.sv ----
`timescale 1ns/1ps
// Port-level checks of the status flag block
module dsf_status_flags_props
   import dsf_pkg::*;
#(
   parameter logic [31:0] LEGAL_OPCODE_MAP = 32'h0000_ffff
) (
   input wire logic              sys_clk_i,
   input wire logic              reset_n_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   input wire logic [DATA_W-1:0] prdata_o,
   input wire logic              pready_o,
   input wire logic              cmd_fetch_i,
   input wire logic [CMD_W-1:0]  cmd_code_i,
   input wire logic              cmd_accept_o,
   input wire logic              drawing_halt_o,
   input wire logic              drawing_soft_reset_o,
   input wire logic              draw_break_stop_i,
   input wire logic              cmd_done_i,
   input wire logic              cmd_active_i,
   input wire logic              vblank_i,
   input wire logic              display_reset_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Register index on the bus, low address bits ignored as in the slave
   logic [ADDR_W-1:0] acc_index;
   assign acc_index = paddr_i >> BYTE_SHIFT;
   // Completed write to the clear register
   logic clr_wr;
   assign clr_wr = psel_i && penable_i && pwrite_i && pready_o && acc_index == IDX_FLAG_CLEAR;
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_rd_st;
      s_setup ##0 (!pwrite_i && acc_index == IDX_STATUS);
   endsequence
   // Status read with no soft reset level wiping the flag just before
   sequence s_rd_nosr;
      s_rd_st ##0 !drawing_soft_reset_o;
   endsequence
   a_pready_once: assert property (s_setup |=> pready_o ##1 !pready_o)
      else $error("pready not a single access cycle");
   a_err_sets: assert property (
      cmd_fetch_i && cmd_accept_o && !LEGAL_OPCODE_MAP[cmd_code_i[OPCODE_LSB +: OPCODE_W]]
      |=> drawing_halt_o)
      else $error("bad opcode did not halt");
   a_halt_blocks: assert property (drawing_halt_o [*2] |-> !cmd_accept_o)
      else $error("fetch allowed while halted");
   a_halt_sticky: assert property ($fell(drawing_halt_o) |->
      $past(clr_wr && pwdata_i[BIT_CMD_ERROR]) || drawing_soft_reset_o ||
      $past(drawing_soft_reset_o))
      else $error("error flag dropped by itself");
   a_clr_reads0: assert property (
      s_setup ##0 (!pwrite_i && acc_index == IDX_FLAG_CLEAR) |=> prdata_o == 32'h0000_0000)
      else $error("clear register read not zero");
   // Event, then one cycle free of clears, then the status read setup
   a_break_sets: assert property (
      draw_break_stop_i ##1 !clr_wr ##1 s_rd_nosr |=> prdata_o[BIT_DRAW_BREAK])
      else $error("break flag not set");
   a_end_sets: assert property (
      (cmd_done_i || !cmd_active_i) ##1 !clr_wr ##1 s_rd_nosr |=> prdata_o[BIT_CMD_END])
      else $error("end flag not set");
   a_vb_sets: assert property (
      $rose(vblank_i) ##1 !clr_wr ##1 (s_rd_st ##0 !display_reset_o) |=> prdata_o[BIT_VBLANK])
      else $error("blank flag not set");
endmodule : dsf_status_flags_props

bind dsf_status_flags dsf_status_flags_props #(.LEGAL_OPCODE_MAP(LEGAL_OPCODE_MAP)) u_props (
   .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .cmd_fetch_i(cmd_fetch_i), .cmd_code_i(cmd_code_i),
   .cmd_accept_o(cmd_accept_o), .drawing_halt_o(drawing_halt_o),
   .drawing_soft_reset_o(drawing_soft_reset_o), .draw_break_stop_i(draw_break_stop_i),
   .cmd_done_i(cmd_done_i), .cmd_active_i(cmd_active_i), .vblank_i(vblank_i),
   .display_reset_o(display_reset_o));
